// file: rtl/pcg_consts.svh
// Register indices, field positions, reset values and timing counts of the clock gating block
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// Register indices; byte address is four times the index
`define PCG_IDX_STOP0    10'h064
`define PCG_IDX_STOP1    10'h065
`define PCG_IDX_PLL      10'h066
`define PCG_IDX_DCDC     10'h067
`define PCG_IDX_PRESC    10'h068
`define PCG_IDX_MCU      10'h069

// Writable masks, reserved bits read as zero
`define PCG_STOP0_MASK   8'hEE
`define PCG_STOP1_MASK   8'h2E
`define PCG_RESET_VAL    8'h00

// Stop register 0 fields
`define PCG_B_TWI        7
`define PCG_B_TIM2       6
`define PCG_B_TIM0       5
`define PCG_B_TIM1       3
`define PCG_B_SPI        2
`define PCG_B_USART0     1
// Stop register 1 fields
`define PCG_B_KEYPAD     5
`define PCG_B_SCARD      3
`define PCG_B_FSPI       2
`define PCG_B_USB        1

// PLL control fields
`define PCG_B_PLL_ON     0
`define PCG_B_PLL_SEL    1
`define PCG_B_PLL_LOCK   2
// DC/DC control fields
`define PCG_B_DCDC_ON    0
`define PCG_B_DCDC_RDY   1
// MCU control field
`define PCG_B_DBG_DIS    7

// Number of gated peripherals
`define PCG_NUM_PER      10

// Timing: clock period and converter sequence times in ns
`define PCG_CLK_NS       20
`define PCG_DCDC_UP_NS   1000
`define PCG_DCDC_DOWN_NS 500
`define PCG_DCDC_UP_CYC   ((`PCG_DCDC_UP_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS)
`define PCG_DCDC_DOWN_CYC ((`PCG_DCDC_DOWN_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS)

`endif

// file: rtl/pcg_pkg.sv
// Types of the clock gating block
package pcg_pkg;
  typedef enum logic [1:0] {
    DCDC_OFF,
    DCDC_RISE,
    DCDC_ON,
    DCDC_FALL
  } pcg_dcdc_state_e;
  typedef logic [15:0] pcg_count_t;
endpackage

// file: rtl/pcg_sync3.sv
// Three-stage input synchroniser with agreement filter
module pcg_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  genvar i;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only when second and third stage agree
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        q[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        q[i] <= s3_r[i];
      end
    end
  end
endmodule // pcg_sync3

// file: rtl/pcg_gate_cell.sv
// One peripheral clock enable and register access gate
module pcg_gate_cell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic stop,
  output logic      clk_en,
  output logic      io_en
);
  // Enable changes only at a rising edge, so every enabled cycle is whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en <= 1'b1;
      io_en  <= 1'b1;
    end else begin
      clk_en <= ~stop;
      io_en  <= ~stop;
    end
  end
endmodule // pcg_gate_cell

// file: rtl/pcg_top.sv
// Peripheral clock gating block with its power control registers
`include "pcg_consts.svh"

module pcg_top #(
  parameter int DCDC_UP_CYC   = `PCG_DCDC_UP_CYC,
  parameter int DCDC_DOWN_CYC = `PCG_DCDC_DOWN_CYC
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RSTN,
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [11:0]              WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output logic      [31:0]              WB_DAT_O,
  output logic                          WB_ACK_O,
  input  wire logic                     TIM2_ASYNC_SEL,
  input  wire logic                     SLEEP_DEEP,
  input  wire logic                     WDT_ENABLE,
  input  wire logic                     BROWNOUT_ENABLE_FUSE,
  input  wire logic                     DEBUG_ENABLE_FUSE,
  input  wire logic                     SCAN_PORT_ENABLE_FUSE,
  input  wire logic                     PLL_LOCK,
  output logic      [`PCG_NUM_PER-1:0]  PER_CLK_EN,
  output logic      [`PCG_NUM_PER-1:0]  PER_IO_EN,
  output logic                          PLL_ON,
  output logic                          PLL_OUTPUT_SELECT,
  output logic                          DCDC_ON,
  output logic      [7:0]               CLK_PRESCALE,
  output logic                          BOD_ACTIVE,
  output logic                          WDT_RUN,
  output logic                          MAIN_CLK_KEEP,
  output logic                          DEBUG_ACTIVE
);

  // Reset release
  logic rst_a_r;
  logic rst_n;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // Fuse and lock inputs from outside the clock domain
  logic [3:0] pin_sync;
  wire        bod_fuse  = pin_sync[0];
  wire        dbg_fuse  = pin_sync[1];
  wire        scan_fuse = pin_sync[2];
  wire        pll_lock  = pin_sync[3];

  pcg_sync3 #(
    .W (4)
  ) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .d     ({PLL_LOCK, SCAN_PORT_ENABLE_FUSE, DEBUG_ENABLE_FUSE, BROWNOUT_ENABLE_FUSE}),
    .q     (pin_sync)
  );

  // Software registers
  logic [7:0] stop0_r;
  logic [7:0] stop1_r;
  logic       pll_on_r;
  logic       pll_sel_r;
  logic       dcdc_on_r;
  logic [7:0] presc_r;
  logic       dbg_dis_r;
  logic       dcdc_rdy_r;

  // Bus decode
  wire [9:0] idx      = WB_ADR_I[11:2];
  wire       req      = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire       wr_lo    = req & WB_WE_I & WB_SEL_I[0];
  wire [7:0] wd       = WB_DAT_I[7:0];
  wire       hit_s0   = idx == `PCG_IDX_STOP0;
  wire       hit_s1   = idx == `PCG_IDX_STOP1;
  wire       hit_pll  = idx == `PCG_IDX_PLL;
  wire       hit_dcdc = idx == `PCG_IDX_DCDC;
  wire       hit_psc  = idx == `PCG_IDX_PRESC;
  wire       hit_mcu  = idx == `PCG_IDX_MCU;

  // Register writes
  wire [7:0] stop0_nxt = (wr_lo & hit_s0) ? (wd & `PCG_STOP0_MASK) : stop0_r;
  wire [7:0] stop1_nxt = (wr_lo & hit_s1) ? (wd & `PCG_STOP1_MASK) : stop1_r;
  wire       pll_on_nxt  = (wr_lo & hit_pll) ? wd[`PCG_B_PLL_ON] : pll_on_r;
  wire       pll_sel_nxt = (wr_lo & hit_pll) ? wd[`PCG_B_PLL_SEL] : pll_sel_r;
  wire       dcdc_on_nxt = (wr_lo & hit_dcdc) ? wd[`PCG_B_DCDC_ON] : dcdc_on_r;
  wire [7:0] presc_nxt   = (wr_lo & hit_psc) ? wd : presc_r;
  wire       dbg_dis_nxt = (wr_lo & hit_mcu) ? wd[`PCG_B_DBG_DIS] : dbg_dis_r;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stop0_r <= `PCG_RESET_VAL;
      stop1_r <= `PCG_RESET_VAL;
    end else begin
      stop0_r <= stop0_nxt;
      stop1_r <= stop1_nxt;
    end
  end

  // PLL and converter stay as software leaves them, nothing here touches them on sleep
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pll_on_r  <= 1'b0;
      pll_sel_r <= 1'b0;
      dcdc_on_r <= 1'b0;
      presc_r   <= 8'h00;
      dbg_dis_r <= 1'b0;
    end else begin
      pll_on_r  <= pll_on_nxt;
      pll_sel_r <= pll_sel_nxt;
      dcdc_on_r <= dcdc_on_nxt;
      presc_r   <= presc_nxt;
      dbg_dis_r <= dbg_dis_nxt;
    end
  end

  // Read multiplexer
  wire [7:0] rd_pll  = {5'h00, pll_lock, pll_sel_r, pll_on_r};
  wire [7:0] rd_dcdc = {6'h00, dcdc_rdy_r, dcdc_on_r};
  wire [7:0] rd_mcu  = {dbg_dis_r, 7'h00};
  wire [7:0] rd_sel  = hit_s0   ? stop0_r :
                       hit_s1   ? stop1_r :
                       hit_pll  ? rd_pll  :
                       hit_dcdc ? rd_dcdc :
                       hit_psc  ? presc_r :
                       hit_mcu  ? rd_mcu  : 8'h00;
  wire [31:0] rd_nxt = (req & ~WB_WE_I) ? {24'h0000_00, rd_sel} : 32'h0000_0000;

  // Single-cycle acknowledge, unmapped addresses answer zero
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= rd_nxt;
    end
  end

  // Stop requests per peripheral
  logic [`PCG_NUM_PER-1:0] stop_vec;

  assign stop_vec[0] = stop0_r[`PCG_B_TWI];
  assign stop_vec[1] = stop0_r[`PCG_B_TIM2] & ~TIM2_ASYNC_SEL;
  assign stop_vec[2] = stop0_r[`PCG_B_TIM0];
  assign stop_vec[3] = stop0_r[`PCG_B_TIM1];
  assign stop_vec[4] = stop0_r[`PCG_B_SPI];
  assign stop_vec[5] = stop0_r[`PCG_B_USART0];
  assign stop_vec[6] = stop1_r[`PCG_B_KEYPAD];
  assign stop_vec[7] = stop1_r[`PCG_B_SCARD];
  assign stop_vec[8] = stop1_r[`PCG_B_FSPI];
  assign stop_vec[9] = stop1_r[`PCG_B_USB];

  // Enables only hold the peripheral, its state is untouched while stopped
  genvar g;
  for (g = 0; g < `PCG_NUM_PER; g++) begin : g_gate
    pcg_gate_cell u_gate (
      .clk    (SYS_CLK),
      .rst_n  (rst_n),
      .stop   (stop_vec[g]),
      .clk_en (PER_CLK_EN[g]),
      .io_en  (PER_IO_EN[g])
    );
  end

  // Converter sequencer
  pcg_pkg::pcg_dcdc_state_e dcdc_st_r;
  pcg_pkg::pcg_dcdc_state_e dcdc_st_nxt;
  pcg_pkg::pcg_count_t      dcdc_cnt_r;
  pcg_pkg::pcg_count_t      dcdc_cnt_nxt;
  logic                     dcdc_rdy_nxt;

  localparam pcg_pkg::pcg_count_t UP_LOAD   = pcg_pkg::pcg_count_t'(DCDC_UP_CYC - 1);
  localparam pcg_pkg::pcg_count_t DOWN_LOAD = pcg_pkg::pcg_count_t'(DCDC_DOWN_CYC - 1);

  wire cnt_zero = dcdc_cnt_r == 16'h0000;

  always_comb begin
    dcdc_st_nxt  = dcdc_st_r;
    dcdc_cnt_nxt = cnt_zero ? dcdc_cnt_r : dcdc_cnt_r - 16'h0001;
    dcdc_rdy_nxt = dcdc_rdy_r;
    unique case (dcdc_st_r)
      pcg_pkg::DCDC_OFF: begin
        if (dcdc_on_r) begin
          dcdc_st_nxt  = pcg_pkg::DCDC_RISE;
          dcdc_cnt_nxt = UP_LOAD;
        end
      end
      pcg_pkg::DCDC_RISE: begin
        if (!dcdc_on_r) begin
          dcdc_st_nxt  = pcg_pkg::DCDC_FALL;
          dcdc_cnt_nxt = DOWN_LOAD;
        end else if (cnt_zero) begin
          dcdc_st_nxt  = pcg_pkg::DCDC_ON;
          dcdc_rdy_nxt = 1'b1;
        end
      end
      pcg_pkg::DCDC_ON: begin
        if (!dcdc_on_r) begin
          dcdc_st_nxt  = pcg_pkg::DCDC_FALL;
          dcdc_cnt_nxt = DOWN_LOAD;
        end
      end
      pcg_pkg::DCDC_FALL: begin
        if (cnt_zero) begin
          dcdc_st_nxt  = pcg_pkg::DCDC_OFF;
          dcdc_rdy_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dcdc_st_r  <= pcg_pkg::DCDC_OFF;
      dcdc_cnt_r <= 16'h0000;
      dcdc_rdy_r <= 1'b0;
    end else begin
      dcdc_st_r  <= dcdc_st_nxt;
      dcdc_cnt_r <= dcdc_cnt_nxt;
      dcdc_rdy_r <= dcdc_rdy_nxt;
    end
  end

  wire dcdc_drive = (dcdc_st_r == pcg_pkg::DCDC_RISE) | (dcdc_st_r == pcg_pkg::DCDC_ON);

  // Always-on functions and debug
  wire dbg_on = dbg_fuse & scan_fuse & ~dbg_dis_r;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PLL_ON            <= 1'b0;
      PLL_OUTPUT_SELECT <= 1'b0;
      DCDC_ON           <= 1'b0;
      CLK_PRESCALE      <= 8'h00;
      BOD_ACTIVE        <= 1'b0;
      WDT_RUN           <= 1'b0;
      MAIN_CLK_KEEP     <= 1'b0;
      DEBUG_ACTIVE      <= 1'b0;
    end else begin
      PLL_ON            <= pll_on_r;
      PLL_OUTPUT_SELECT <= pll_sel_r;
      DCDC_ON           <= dcdc_drive;
      CLK_PRESCALE      <= presc_r;
      BOD_ACTIVE        <= bod_fuse;
      WDT_RUN           <= WDT_ENABLE;
      MAIN_CLK_KEEP     <= dbg_on & SLEEP_DEEP;
      DEBUG_ACTIVE      <= dbg_on;
    end
  end

endmodule // pcg_top

// file: bench/pcg_top_monitor.sv
// Port assertions of the clock gating block
`include "pcg_consts.svh"
module pcg_top_monitor (
  input wire logic                    SYS_CLK,
  input wire logic                    RSTN,
  input wire logic                    WB_CYC_I,
  input wire logic                    WB_STB_I,
  input wire logic                    WB_WE_I,
  input wire logic [11:0]             WB_ADR_I,
  input wire logic [3:0]              WB_SEL_I,
  input wire logic [31:0]             WB_DAT_I,
  input wire logic [31:0]             WB_DAT_O,
  input wire logic                    WB_ACK_O,
  input wire logic                    TIM2_ASYNC_SEL,
  input wire logic                    SLEEP_DEEP,
  input wire logic                    WDT_ENABLE,
  input wire logic [`PCG_NUM_PER-1:0] PER_CLK_EN,
  input wire logic [`PCG_NUM_PER-1:0] PER_IO_EN,
  input wire logic                    PLL_ON,
  input wire logic                    DCDC_ON,
  input wire logic                    WDT_RUN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  // Internal reset leaves two edges after RSTN, outputs settle one edge later
  logic [1:0] warm_r;
  default disable iff (!RSTN || warm_r != 2'h3);
  logic [9:0] idx_r;
  logic       we_r;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  wire        req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire        wr0 = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[11:2] == `PCG_IDX_STOP0;
  wire [7:0]  rmask = idx_r == `PCG_IDX_STOP0 ? ~`PCG_STOP0_MASK :
                      idx_r == `PCG_IDX_STOP1 ? ~`PCG_STOP1_MASK : 8'h00;
  always_ff @(posedge SYS_CLK) begin
    idx_r <= WB_ADR_I[11:2];
    we_r  <= WB_WE_I;
  end
  ack_answer_a: assert property (req |=> WB_ACK_O) else $error("no ack after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  idle_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("data without ack");
  rsv_read_a: assert property (WB_ACK_O && !we_r |-> (WB_DAT_O[7:0] & rmask) == 8'h00)
    else $error("reserved bit read as one");
  gate_twi_a: assert property (wr0 |-> ##2 PER_CLK_EN[0] != $past(WB_DAT_I[7], 2))
    else $error("two-wire clock enable wrong");
  io_match_a: assert property (PER_IO_EN == PER_CLK_EN) else $error("access and clock differ");
  tim2_async_a: assert property (TIM2_ASYNC_SEL [*3] |-> PER_CLK_EN[1])
    else $error("async timer2 stopped");
  wdt_run_a: assert property (WDT_ENABLE [*3] |-> WDT_RUN) else $error("watchdog stopped");
  sleep_hold_a: assert property ((!WB_STB_I) [*4] ##0 $rose(SLEEP_DEEP) |=> $stable(PLL_ON) && $stable(DCDC_ON))
    else $error("sleep switched pll or converter");
  cover property (wr0);
  cover property (WB_ACK_O && !we_r);
  cover property ($rose(SLEEP_DEEP) && PLL_ON);
endmodule // pcg_top_monitor

bind pcg_top pcg_top_monitor mon_u (.SYS_CLK, .RSTN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
  .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TIM2_ASYNC_SEL, .SLEEP_DEEP, .WDT_ENABLE, .PER_CLK_EN, .PER_IO_EN,
  .PLL_ON, .DCDC_ON, .WDT_RUN);

// file: bench/pcg_far_model.sv
// Far side model: gated timer0 counter and PLL lock
`include "pcg_consts.svh"
module pcg_far_model (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [`PCG_NUM_PER-1:0] clk_en,
  input  wire logic                    pll_on,
  output logic                         pll_lock,
  output logic      [15:0]             tim0_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] lock_r;
  assign pll_lock = lock_r[2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r   <= 3'h0;
      tim0_cnt <= 16'h0000;
    end else begin
      lock_r <= {lock_r[1:0], pll_on};
      if (clk_en[2]) tim0_cnt <= tim0_cnt + 16'h0001;
    end
  end
endmodule // pcg_far_model

// file: bench/testbench.sv
// Self-checking bench of the clock gating block
`include "pcg_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, cyc, stb, we, as2, slp, wdt, bod, dbg, scan;
  logic        ack, pll_on, pll_sel, pll_lock, dcdc_on, bod_act, wdt_run, keep, dbg_act;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, v, u;
  logic [7:0]  presc;
  logic [9:0]  clk_en, io_en, e;
  logic [15:0] cnt, snap;
  logic [31:0] expq[$];
  int          bad_count = 0, check_count = 0, tcnt = 0, seed, k;
  pcg_top #(.DCDC_UP_CYC(4), .DCDC_DOWN_CYC(8)) dut_u (.SYS_CLK(clk), .RSTN(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .TIM2_ASYNC_SEL(as2), .SLEEP_DEEP(slp), .WDT_ENABLE(wdt), .BROWNOUT_ENABLE_FUSE(bod),
    .DEBUG_ENABLE_FUSE(dbg), .SCAN_PORT_ENABLE_FUSE(scan), .PLL_LOCK(pll_lock), .PER_CLK_EN(clk_en),
    .PER_IO_EN(io_en), .PLL_ON(pll_on), .PLL_OUTPUT_SELECT(pll_sel), .DCDC_ON(dcdc_on),
    .CLK_PRESCALE(presc), .BOD_ACTIVE(bod_act), .WDT_RUN(wdt_run), .MAIN_CLK_KEEP(keep),
    .DEBUG_ACTIVE(dbg_act));
  pcg_far_model far_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .pll_on(pll_on), .pll_lock(pll_lock),
    .tim0_cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d, input logic [7:0] x);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= {24'h00_0000, d};
    if (!w) expq.push_back({24'h00_0000, x});
    @(negedge clk);
    while (ack !== 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(negedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk(dat_o, expq.pop_front());
  end
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    if (tcnt == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    seed = 2;
    {cyc, stb, we, as2, slp} = 5'h00;
    {wdt, bod, dbg, scan} = 4'hF;
    adr = 12'h000;
    sel = 4'h1;
    dat = 32'h0000_0000;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wb(0, `PCG_IDX_STOP0, 8'h00, `PCG_RESET_VAL);
    wb(0, `PCG_IDX_STOP1, 8'h00, `PCG_RESET_VAL);
    chk(clk_en, 10'h3FF);
    wb(0, 10'h3FF, 8'h00, 8'h00);
    for (k = 0; k < 6; k++) begin
      v = $random(seed);
      u = $random(seed);
      if (k == 0) v = 32'h0000_00FF;
      as2 <= v[8];
      wb(1, `PCG_IDX_STOP0, v[7:0], 8'h00);
      wb(1, `PCG_IDX_STOP1, u[7:0], 8'h00);
      wb(0, `PCG_IDX_STOP0, 8'h00, v[7:0] & `PCG_STOP0_MASK);
      wb(0, `PCG_IDX_STOP1, 8'h00, u[7:0] & `PCG_STOP1_MASK);
      e = ~{u[1], u[2], u[3], u[5], v[1], v[2], v[3], v[5], v[6] & ~v[8], v[7]};
      @(negedge clk);
      chk(clk_en, e);
      chk(io_en, e);
      snap = cnt;
      repeat (5) @(negedge clk);
      chk(cnt, snap + (e[2] ? 16'h0005 : 16'h0000));
    end
    wb(1, `PCG_IDX_DCDC, 8'h01, 8'h00);
    wb(1, `PCG_IDX_PLL, 8'h03, 8'h00);
    repeat (14) @(negedge clk);
    wb(0, `PCG_IDX_DCDC, 8'h00, 8'h03);
    wb(0, `PCG_IDX_PLL, 8'h00, 8'h07);
    repeat (5) @(posedge clk);
    slp <= 1'b1;
    repeat (4) @(negedge clk);
    chk({pll_on, dcdc_on}, 2'h3);
    chk({keep, bod_act, wdt_run}, 3'h7);
    slp <= 1'b0;
    wb(1, `PCG_IDX_PLL, 8'h01, 8'h00);
    wb(1, `PCG_IDX_PLL, 8'h00, 8'h00);
    wb(1, `PCG_IDX_DCDC, 8'h00, 8'h00);
    wb(0, `PCG_IDX_DCDC, 8'h00, 8'h02);
    repeat (14) @(negedge clk);
    wb(0, `PCG_IDX_DCDC, 8'h00, 8'h00);
    wb(0, `PCG_IDX_PLL, 8'h00, 8'h00);
    chk(dcdc_on, 1'b0);
    wb(1, `PCG_IDX_PRESC, 8'h03, 8'h00);
    wb(1, `PCG_IDX_PRESC, 8'h00, 8'h00);
    wb(0, `PCG_IDX_PRESC, 8'h00, 8'h00);
    chk(presc, 8'h00);
    chk(dbg_act, 1'b1);
    wb(1, `PCG_IDX_MCU, 8'h80, 8'h00);
    repeat (3) @(negedge clk);
    chk(dbg_act, 1'b0);
    wb(1, `PCG_IDX_PLL, 8'h03, 8'h00);
    wb(1, `PCG_IDX_DCDC, 8'h01, 8'h00);
    repeat (14) @(negedge clk);
    wb(0, `PCG_IDX_DCDC, 8'h00, 8'h03);
    wb(0, `PCG_IDX_PLL, 8'h00, 8'h07);
    close_out();
  end
endmodule // testbench
